// ==== design/apr_readout.sv ====
// Accelerometer read-out path: link bytes into a FIFO, out by serial pipe or registers.
//
// Function
// - Serial pipe forwards only when path select set.
// - Registers forward only when path select cleared.
// - Serial pipe read-only; master drives select, clock.
// - Output changes on rising edge, sampled falling.
// - Bytes shifted out most significant bit first.
// - Status byte first, then its data byte.
// - Status at 2Dh, data at 2Eh.
// - Upper-half byte bit 7 one, lower zero.
// - Status read pops entry, held for data.
// - Status: zero high nibble, full, empty, error, special.
// - Data reads buffered byte, zero when empty.
// - Latest acceleration offered for resource read.
// - Buffer of 64 bits, empty and overrun reported.
`timescale 1ns/1ps
`default_nettype none
`include "apr_params.svh"

module apr_readout (
  // Clock and synchronous reset.
  input wire logic CLOCK,
  input wire logic RST,
  // Accelerometer chunks from the link receiver, same clock.
  input wire apr_pkg::apr_link_type LINK_IN,
  // Serial path select bit of the system control register.
  input wire logic SERIAL_PATH_SELECT,
  // Serial pipe pins, asynchronous to CLOCK.
  input wire logic SPI_SEL_N,
  input wire logic SPI_CLK,
  output logic SPI_MISO,
  // Drive register interface read port.
  input wire apr_pkg::apr_rd_req_type REG_REQ,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // Latest acceleration sample for the resource read path.
  output logic [13:0] ACCEL_SAMPLE,
  output logic ACCEL_FRESH
);
  import apr_pkg::*;

  // Builds the status byte for an entry about to be handed out.
  function automatic logic [7:0] apr_status(input logic full, input logic empty,
                                            input apr_entry_type ent);
    logic [7:0] st;
    st = `APR_ZERO_BYTE;
    st[`APR_ST_FULL] = full;
    st[`APR_ST_EMPTY] = empty;
    st[`APR_ST_ERR] = !empty && ent.corrupt;
    st[`APR_ST_SCI] = !empty && ent.special;
    return st;
  endfunction

  // Synchroniser stages for select (bit 1) and clock (bit 0).
  logic [1:0] pin_in;
  logic [1:0] sync_r [`APR_SYNC_STAGES];
  logic [1:0] pin_prev_r;
  logic sel_start;
  logic sel_end;
  logic clk_rise;

  // FIFO connections.
  apr_entry_type push_entry;
  apr_entry_type head_entry;
  logic fifo_full;
  logic fifo_empty;
  logic [`APR_FIFO_AW:0] fifo_level;
  logic fifo_pop;

  // Current status and data of the head entry.
  logic [7:0] head_status;
  logic [7:0] head_data;

  // Serial shifter state.
  apr_spi_state_type spi_state_r;
  logic [15:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic miso_r;
  logic spi_pop;

  // Register read state.
  logic reg_status_rd;
  logic reg_data_rd;
  logic [7:0] hold_data_r;
  logic [7:0] rdata_r;
  logic rvalid_r;

  // Sample assembly for the resource read path.
  logic [6:0] upper_r;
  logic [13:0] sample_r;
  logic fresh_r;

  assign pin_in = {SPI_SEL_N, SPI_CLK};

  // Two-flop synchronisers; only the second stage feeds any logic.
  genvar g;
  generate
    for (g = 0; g < `APR_SYNC_STAGES; g++) begin : g_sync
      if (g == 0) begin : g_first
        // First stage takes the raw pins; it may go metastable, so nothing else reads it.
        always_ff @(posedge CLOCK) begin
          if (RST) begin
            sync_r[g] <= `APR_PIN_IDLE;
          end else begin
            sync_r[g] <= pin_in;
          end
        end
      end else begin : g_next
        // Later stages only copy the stage before them.
        always_ff @(posedge CLOCK) begin
          if (RST) begin
            sync_r[g] <= `APR_PIN_IDLE;
          end else begin
            sync_r[g] <= sync_r[g-1];
          end
        end
      end
    end
  endgenerate

  // Previous synchronised levels for edge detection.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pin_prev_r <= `APR_PIN_IDLE;
    end else begin
      pin_prev_r <= sync_r[`APR_SYNC_STAGES-1];
    end
  end

  // Select is active low, so its falling edge starts a transaction.
  assign sel_start = pin_prev_r[1] && !sync_r[`APR_SYNC_STAGES-1][1];
  assign sel_end = !pin_prev_r[1] && sync_r[`APR_SYNC_STAGES-1][1];
  assign clk_rise = !pin_prev_r[0] && sync_r[`APR_SYNC_STAGES-1][0];

  // Each link chunk becomes one byte whose bit 7 marks the upper half.
  always_comb begin
    push_entry.corrupt = LINK_IN.corrupt;
    push_entry.special = LINK_IN.special;
    push_entry.data = {LINK_IN.upper, LINK_IN.chunk};
  end

  // Pops come from a pipe select or a status register read, never both.
  assign spi_pop = sel_start && SERIAL_PATH_SELECT;
  assign reg_status_rd = REG_REQ.strobe && (REG_REQ.addr == `APR_ADDR_STATUS)
                         && !SERIAL_PATH_SELECT;
  assign reg_data_rd = REG_REQ.strobe && (REG_REQ.addr == `APR_ADDR_DATA)
                       && !SERIAL_PATH_SELECT;
  assign fifo_pop = spi_pop || reg_status_rd;

  // Byte buffer of 64 bits; overrun shows as the full flag.
  apr_fifo u_fifo (
    .clock(CLOCK),
    .rst(RST),
    .push(LINK_IN.valid),
    .push_entry(push_entry),
    .pop(fifo_pop),
    .head_entry(head_entry),
    .full(fifo_full),
    .empty(fifo_empty),
    .level(fifo_level)
  );

  // The status describes exactly the byte that is handed out with it.
  assign head_status = apr_status(fifo_full, fifo_empty, head_entry);
  assign head_data = fifo_empty ? `APR_ZERO_BYTE : head_entry.data;

  // Serial shifter: load at select, shift on each rising serial clock edge.
  // The master samples on falling edges, so the sync latency of a few cycles
  // stays well inside the half period of the serial clock.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      spi_state_r <= APR_SP_IDLE;
      shift_r <= '0;
      bit_cnt_r <= `APR_XFER_FIRST;
      miso_r <= 1'b0;
    end else if (!SERIAL_PATH_SELECT || sel_end) begin
      // Deselect or path change ends the transaction; output holds.
      spi_state_r <= APR_SP_IDLE;
    end else if (sel_start) begin
      spi_state_r <= APR_SP_SHIFT;
      shift_r <= {head_status, head_data};
      bit_cnt_r <= `APR_XFER_FIRST;
    end else begin
      unique case (spi_state_r)
        APR_SP_IDLE: begin
          spi_state_r <= APR_SP_IDLE;
        end
        APR_SP_SHIFT: begin
          if (clk_rise) begin
            miso_r <= shift_r[15];
            shift_r <= {shift_r[14:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + `APR_XFER_STEP;
            if (bit_cnt_r == `APR_XFER_LAST) begin
              spi_state_r <= APR_SP_HOLD;
            end
          end
        end
        APR_SP_HOLD: begin
          // Extra clocks after sixteen bits are ignored.
          spi_state_r <= APR_SP_HOLD;
        end
        default: begin
          spi_state_r <= APR_SP_IDLE;
        end
      endcase
    end
  end

  // Register reads: status pops and holds the byte for the next data read.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      hold_data_r <= `APR_ZERO_BYTE;
      rdata_r <= `APR_ZERO_BYTE;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= REG_REQ.strobe;
      if (reg_status_rd) begin
        rdata_r <= head_status;
        hold_data_r <= head_data;
      end else if (reg_data_rd) begin
        rdata_r <= hold_data_r;
      end else begin
        // Unmapped addresses and the serial mode read as zero.
        rdata_r <= `APR_ZERO_BYTE;
      end
    end
  end

  // Latest full sample for the slow resource path: upper half, then lower.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      upper_r <= '0;
      sample_r <= '0;
      fresh_r <= 1'b0;
    end else begin
      fresh_r <= 1'b0;
      if (LINK_IN.valid && LINK_IN.upper) begin
        upper_r <= LINK_IN.chunk;
      end else if (LINK_IN.valid) begin
        sample_r <= {upper_r, LINK_IN.chunk};
        fresh_r <= 1'b1;
      end
    end
  end

  assign SPI_MISO = miso_r;
  assign REG_RDATA = rdata_r;
  assign REG_RVALID = rvalid_r;
  assign ACCEL_SAMPLE = sample_r;
  assign ACCEL_FRESH = fresh_r;

  // Checks on the behaviour above.
  default clocking apr_cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  // First and last shift steps of a pipe transaction.
  sequence apr_first_bit_s;
    (spi_state_r == APR_SP_SHIFT) && (bit_cnt_r == `APR_XFER_FIRST) && clk_rise
    && SERIAL_PATH_SELECT && !sel_end && !sel_start;
  endsequence

  sequence apr_last_bit_s;
    (spi_state_r == APR_SP_SHIFT) && (bit_cnt_r == `APR_XFER_LAST) && clk_rise
    && SERIAL_PATH_SELECT && !sel_end && !sel_start;
  endsequence

  serial_gate_a: assert property (!SERIAL_PATH_SELECT |=> spi_state_r == APR_SP_IDLE)
    else $error("Serial pipe active while path select cleared.");

  register_gate_a: assert property (SERIAL_PATH_SELECT && REG_REQ.strobe
                                    |=> REG_RVALID && REG_RDATA == `APR_ZERO_BYTE)
    else $error("Register outlet returned data in serial mode.");

  miso_stable_a: assert property (spi_state_r != APR_SP_SHIFT |=> $stable(SPI_MISO))
    else $error("Serial output moved outside a shift.");

  status_first_a: assert property (apr_first_bit_s |=> SPI_MISO == 1'b0)
    else $error("First bit out was not the zero status top bit.");

  byte_count_a: assert property (apr_last_bit_s |=> spi_state_r == APR_SP_HOLD)
    else $error("Transaction did not end after sixteen bits.");

  restart_a: assert property (sel_start && SERIAL_PATH_SELECT
                              |=> spi_state_r == APR_SP_SHIFT
                              && bit_cnt_r == `APR_XFER_FIRST)
    else $error("Select did not restart at the status byte.");

  status_layout_a: assert property (reg_status_rd
                                    |=> REG_RDATA[7:4] == 4'h0
                                    && REG_RDATA[`APR_ST_EMPTY] == $past(fifo_empty))
    else $error("Status byte layout wrong.");

  empty_data_a: assert property (reg_status_rd && fifo_empty
                                 |=> hold_data_r == `APR_ZERO_BYTE)
    else $error("Empty FIFO handed out nonzero data.");

  pop_count_a: assert property (reg_status_rd && !fifo_empty && !LINK_IN.valid
                                |=> fifo_level == $past(fifo_level) - `APR_LEVEL_ONE)
    else $error("Status read did not pop one entry.");

endmodule

`default_nettype wire

// ==== design/apr_params.svh ====
// Constants of the accelerometer read-out path: addresses, field positions, sizes.
`ifndef APR_PARAMS_SVH
`define APR_PARAMS_SVH

// Register addresses on the drive register interface.
`define APR_ADDR_STATUS 8'h2D
`define APR_ADDR_DATA 8'h2E

// FIFO geometry: eight bytes, 64 bits of accelerometer data.
`define APR_FIFO_DEPTH 8
`define APR_FIFO_AW 3
`define APR_LEVEL_ONE 4'h1

// Serial transaction: status byte then data byte, 16 bits.
`define APR_XFER_FIRST 4'h0
`define APR_XFER_LAST 4'hF
`define APR_XFER_STEP 4'h1

// Status byte field positions.
`define APR_ST_FULL 3
`define APR_ST_EMPTY 2
`define APR_ST_ERR 1
`define APR_ST_SCI 0

// Misc values.
`define APR_ZERO_BYTE 8'h00
`define APR_UPPER_FLAG 7
`define APR_SYNC_STAGES 2
// Idle pin levels {select, clock}: deselected, clock parked low.
`define APR_PIN_IDLE 2'h2

`endif

// ==== design/apr_pkg.sv ====
// Types shared by the accelerometer read-out path.
`include "apr_params.svh"

package apr_pkg;

  // One buffered byte with its link quality flags.
  typedef struct packed {
    logic corrupt;
    logic special;
    logic [7:0] data;
  } apr_entry_type;

  // One accelerometer chunk delivered by the link receiver.
  typedef struct packed {
    logic valid;
    logic upper;
    logic corrupt;
    logic special;
    logic [6:0] chunk;
  } apr_link_type;

  // Read request on the drive register interface.
  typedef struct packed {
    logic strobe;
    logic [7:0] addr;
  } apr_rd_req_type;

  // Serial pipe shifter states, Gray coded along idle, shift, hold.
  typedef enum logic [1:0] {
    APR_SP_IDLE = 2'b00,
    APR_SP_SHIFT = 2'b01,
    APR_SP_HOLD = 2'b11
  } apr_spi_state_type;

endpackage

// ==== design/apr_fifo.sv ====
// Eight-entry byte FIFO holding accelerometer bytes with their flags.
`timescale 1ns/1ps
`default_nettype none
`include "apr_params.svh"

module apr_fifo
  import apr_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Filling side.
  input wire logic push,
  input wire apr_pkg::apr_entry_type push_entry,
  // Draining side; head is valid while not empty.
  input wire logic pop,
  output apr_pkg::apr_entry_type head_entry,
  // State.
  output logic full,
  output logic empty,
  output logic [`APR_FIFO_AW:0] level
);

  // Storage array and pointers.
  apr_entry_type mem_r [`APR_FIFO_DEPTH];
  logic [`APR_FIFO_AW-1:0] wr_ptr_r;
  logic [`APR_FIFO_AW-1:0] rd_ptr_r;
  logic [`APR_FIFO_AW:0] level_r;
  logic do_pop;
  logic do_push;

  // A push into a full FIFO is dropped unless a pop frees a slot the same cycle.
  assign do_pop = pop && (level_r != '0);
  assign do_push = push && ((level_r != (`APR_FIFO_AW+1)'(`APR_FIFO_DEPTH)) || do_pop);

  // Data storage.
  always_ff @(posedge clock) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= push_entry;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_push && !do_pop) begin
        level_r <= level_r + `APR_LEVEL_ONE;
      end else if (do_pop && !do_push) begin
        level_r <= level_r - `APR_LEVEL_ONE;
      end
    end
  end

  assign head_entry = mem_r[rd_ptr_r];
  assign empty = (level_r == '0);
  assign full = (level_r == (`APR_FIFO_AW+1)'(`APR_FIFO_DEPTH));
  assign level = level_r;

endmodule

`default_nettype wire

// ==== tb/apr_spi_master.sv ====
// Behavioural serial pipe master that reads one 16-bit transaction per call.
`timescale 1ns/1ps
`default_nettype none

module apr_spi_master (
  // Pipe pins seen from the master side.
  output logic sel_n,
  output logic sclk,
  input wire logic miso
);
  // Half of the 160 ns pipe clock period, well above the 30 ns minimum pulse widths.
  localparam time HALF = 80ns;

  // Idle state: deselected with the clock parked low.
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
  end

  // One read: select, sixteen pulses, output sampled on each falling edge.
  task automatic xfer(output logic [15:0] word);
    word = 16'h0000;
    // Each call stands for one frame's read, started together with the position read.
    sel_n = 1'b0;
    #HALF;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
      word[i] = miso;
      #HALF;
    end
    // The gap after deselect lets the synchronisers see the release.
    sel_n = 1'b1;
    #HALF;
  endtask
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the accelerometer read-out path.
`timescale 1ns/1ps
`default_nettype none
`include "apr_params.svh"

module testbench;
  import apr_pkg::*;
  logic clock; // System clock, 4 ns period.
  logic rst; // Synchronous reset.
  apr_link_type link_in; // Link chunk stimulus.
  logic path_sel; // Serial outlet select level.
  logic sel_n; // Pipe select from the master model.
  logic sclk; // Pipe clock from the master model.
  logic miso; // Pipe data from the design.
  apr_rd_req_type reg_req; // Register read request.
  logic [7:0] reg_rdata; // Register read data.
  logic reg_rvalid; // Register read valid pulse.
  logic [13:0] sample; // Latest assembled sample.
  logic fresh; // Sample update pulse.
  int errors = 0; // Mismatch count.
  int tests_run = 0; // Comparison count.
  logic [7:0] rd; // Scratch register read result.
  logic [15:0] word; // Scratch pipe word.
  logic [7:0] up_byte; // Upper-half byte kept for joining the sample.

  apr_readout apr_readout_inst (.CLOCK(clock), .RST(rst), .LINK_IN(link_in),
    .SERIAL_PATH_SELECT(path_sel), .SPI_SEL_N(sel_n), .SPI_CLK(sclk), .SPI_MISO(miso),
    .REG_REQ(reg_req), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .ACCEL_SAMPLE(sample), .ACCEL_FRESH(fresh));
  apr_spi_master apr_spi_master_inst (.sel_n(sel_n), .sclk(sclk), .miso(miso));

  // Free-running system clock.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // One comparison; a mismatch is printed and counted at once.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Push one link chunk for a single cycle.
  task automatic push(input logic up, input logic cor, input logic spc, input logic [6:0] c);
    @(posedge clock);
    #1 link_in = '{valid: 1'b1, upper: up, corrupt: cor, special: spc, chunk: c};
    @(posedge clock);
    #1 link_in.valid = 1'b0;
  endtask

  // Register read; valid must come exactly one cycle after the strobe is taken.
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1 reg_req = '{strobe: 1'b1, addr: a};
    @(posedge clock);
    // Data and valid stand for exactly the cycle after the taking edge.
    #1 reg_req.strobe = 1'b0;
    d = reg_rdata;
    chk("rvalid", 16'h0001, {15'h0000, reg_rvalid});
  endtask

  // Read an address and compare the returned byte.
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_read(a, rd);
    chk("reg data", {8'h00, exp}, {8'h00, rd});
  endtask

  // Final verdict; the single place where the run ends.
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the tests need about 11 us.
  initial begin
    #200000;
    errors++;
    $display("Error watchdog expected end seen hang");
    stop_test();
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    link_in = '0;
    path_sel = 1'b0;
    reg_req = '0;
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    repeat (3) @(posedge clock);
    // Empty buffer through the registers.
    reg_chk(`APR_ADDR_STATUS, 8'h04);
    reg_chk(`APR_ADDR_DATA, 8'h00);
    $display("Test empty registers done");
    // One sample: upper half flagged corrupt, then lower half.
    push(1'b1, 1'b1, 1'b0, 7'h55);
    push(1'b0, 1'b0, 1'b0, 7'h2A);
    chk("fresh", 16'h0001, {15'h0000, fresh});
    chk("sample", {2'b00, 14'h2AAA}, {2'b00, sample});
    reg_chk(`APR_ADDR_STATUS, 8'h02);
    reg_chk(`APR_ADDR_DATA, 8'hD5);
    up_byte = rd;
    chk("upper mark", 16'h0001, {15'h0000, up_byte[7]});
    reg_chk(`APR_ADDR_DATA, 8'hD5);
    reg_chk(`APR_ADDR_STATUS, 8'h00);
    reg_chk(`APR_ADDR_DATA, 8'h2A);
    chk("joined sample", {2'b00, 14'h2AAA}, {2'b00, up_byte[6:0], rd[6:0]});
    reg_chk(8'h30, 8'h00);
    $display("Test register sample done");
    // Overrun: nine pushes into eight places, the last dropped.
    for (int i = 0; i < 9; i++) begin
      push(1'b0, 1'b0, i == 0, i[6:0]);
    end
    reg_chk(`APR_ADDR_STATUS, 8'h09);
    reg_chk(`APR_ADDR_DATA, 8'h00);
    for (int i = 1; i < 8; i++) begin
      reg_chk(`APR_ADDR_STATUS, 8'h00);
      reg_chk(`APR_ADDR_DATA, {1'b0, i[6:0]});
    end
    reg_chk(`APR_ADDR_STATUS, 8'h04);
    $display("Test overrun done");
    // A pipe transaction in register mode must not take the entry.
    push(1'b1, 1'b0, 1'b0, 7'h11);
    apr_spi_master_inst.xfer(word);
    chk("pipe idle", 16'h0000, word);
    reg_chk(`APR_ADDR_STATUS, 8'h00);
    reg_chk(`APR_ADDR_DATA, 8'h91);
    $display("Test pipe idle in register mode done");
    // Serial mode: registers refused, pipe returns status then data.
    path_sel = 1'b1;
    push(1'b1, 1'b0, 1'b0, 7'h3C);
    reg_chk(`APR_ADDR_STATUS, 8'h00);
    apr_spi_master_inst.xfer(word);
    chk("pipe word", 16'h00BC, word);
    apr_spi_master_inst.xfer(word);
    chk("pipe empty", 16'h0400, word);
    push(1'b0, 1'b0, 1'b1, 7'h4B);
    apr_spi_master_inst.xfer(word);
    chk("pipe special", 16'h014B, word);
    $display("Test serial pipe done");
    stop_test();
  end
endmodule

`default_nettype wire
